// ### rtl/cpu_operand_address_generator.sv
// Operand fetch and address sequencing for an 8-bit core.
// Assumes the memory bus returns each read byte one cycle after mem_rd_o.
`timescale 1ns/1ns
`default_nettype none
module cpu_operand_address_generator
	import opaddr_pkg::*;
(
	input wire logic ref_clk_i, // Core clock
	input wire logic srst_i, // Synchronous reset, active high
	input wire logic start_i, // Begin instruction at pc_i
	input wire logic [ADDR_W-1:0] pc_i, // Opcode address
	input wire instr_info_t info_i, // Decoded opcode info
	input wire logic [7:0] index_i, // Index register
	input wire logic [7:0] reg_val_i, // Register operand for register RMW
	input wire logic [7:0] mem_rdata_i, // Byte from memory bus
	input wire logic [7:0] alu_result_i, // Modified value from ALU
	input wire logic branch_cond_i, // Branch condition true
	output logic busy_o, // Sequence in progress
	output logic mem_rd_o, // Memory read strobe
	output logic mem_wr_o, // Memory write strobe
	output logic [ADDR_W-1:0] mem_addr_o, // Memory address
	output logic [7:0] mem_wdata_o, // Write data
	output logic [7:0] operand_o, // Fetched operand
	output logic operand_valid_o, // Operand ready pulse
	output logic reg_wr_o, // Register write-back pulse
	output logic [7:0] reg_wdata_o, // Register write-back data
	output addr_result_t result_o, // Address result
	output logic done_o // Instruction finished pulse
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_FETCH1 = 7'b0000010,
		ST_FETCH2 = 7'b0000100,
		ST_OPREQ = 7'b0001000,
		ST_OPDATA = 7'b0010000,
		ST_WRITE = 7'b0100000,
		ST_DONE = 7'b1000000
	} seq_state_t;

	seq_state_t state;
	seq_state_t next_state;
	instr_info_t info;
	logic [ADDR_W-1:0] pc;
	logic [7:0] byte1;
	logic [7:0] byte2;
	logic [1:0] got;
	logic [ADDR_W-1:0] ea;
	logic ea_valid;
	logic [1:0] length;
	logic [ADDR_W-1:0] target;
	logic [ADDR_W-1:0] pc_next;
	logic rd_pending;

	// Number of operand bytes after the opcode
	function automatic logic [1:0] extra_bytes(input logic [1:0] len);
		extra_bytes = len - LEN_ONE;
	endfunction

	function automatic logic needs_mem(input instr_info_t i, input logic valid);
		needs_mem = valid && !(i.cls == CLS_RMW && i.rmw_on_reg)
			&& !(i.cls == CLS_TEST_NZ && i.rmw_on_reg);
	endfunction

	opaddr_calc opaddr_calc_inst (
		.mode_i(info.mode),
		.byte1_i(byte1),
		.byte2_i(byte2),
		.index_i(index_i),
		.pc_next_i(pc_next),
		.bit_branch_i(info.cls == CLS_BIT_BRANCH),
		.ea_o(ea),
		.ea_valid_o(ea_valid),
		.length_o(length),
		.target_o(target)
	);

	assign pc_next = pc + {14'h0000, length};

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (start_i) next_state = ST_FETCH1;
			ST_FETCH1: begin
				if (got == extra_bytes(length))
					next_state = needs_mem(info, ea_valid) ? ST_OPREQ : ST_DONE;
				else
					next_state = ST_FETCH2;
			end
			ST_FETCH2: begin
				if (got == extra_bytes(length))
					next_state = needs_mem(info, ea_valid) ? ST_OPREQ : ST_DONE;
			end
			ST_OPREQ: next_state = ST_OPDATA;
			ST_OPDATA: next_state = (info.cls == CLS_RMW) ? ST_WRITE : ST_DONE;
			ST_WRITE: next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Capture opcode info and address at start
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			info <= '0;
			pc <= PC_RESET;
		end else if (state == ST_IDLE && start_i) begin
			info <= info_i;
			pc <= pc_i;
		end
	end

	// Operand byte fetch; bytes in stream order, first is high for 16-bit forms
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			byte1 <= 8'h00;
			byte2 <= 8'h00;
			got <= 2'h0;
			rd_pending <= 1'b0;
		end else if (state == ST_IDLE) begin
			got <= 2'h0;
			rd_pending <= 1'b0;
		end else if (state == ST_FETCH1 || state == ST_FETCH2) begin
			rd_pending <= mem_rd_o;
			if (rd_pending) begin
				if (got == 2'h0)
					byte1 <= mem_rdata_i;
				else
					byte2 <= mem_rdata_i;
				got <= got + 2'h1;
			end
		end
	end

	// Read strobe issued while more operand bytes are outstanding
	always_comb begin
		mem_rd_o = 1'b0;
		mem_addr_o = '0;
		mem_wr_o = 1'b0;
		mem_wdata_o = alu_result_i;
		if ((state == ST_FETCH1 || state == ST_FETCH2) && !rd_pending
			&& got != extra_bytes(length)) begin
			mem_rd_o = 1'b1;
			mem_addr_o = pc + {14'h0000, got} + 16'h0001;
		end else if (state == ST_OPREQ) begin
			mem_rd_o = 1'b1;
			mem_addr_o = ea;
		end else if (state == ST_WRITE && !info.rmw_on_reg) begin
			mem_wr_o = 1'b1;
			mem_addr_o = ea;
		end
	end

	// Operand delivery: memory, register or immediate literal
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			operand_o <= 8'h00;
			operand_valid_o <= 1'b0;
		end else begin
			operand_valid_o <= 1'b0;
			if (state == ST_OPDATA) begin
				operand_o <= mem_rdata_i;
				operand_valid_o <= 1'b1;
			end else if (next_state == ST_DONE && state != ST_DONE
				&& state != ST_WRITE) begin
				if (info.rmw_on_reg) begin
					operand_o <= reg_val_i;
					operand_valid_o <= 1'b1;
				end else if (info.mode == MODE_IMM) begin
					operand_o <= byte1;
					operand_valid_o <= 1'b1;
				end
			end
		end
	end

	// Register read-modify-write; test form leaves the register alone
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			reg_wr_o <= 1'b0;
			reg_wdata_o <= 8'h00;
		end else begin
			reg_wr_o <= (state == ST_DONE) && info.rmw_on_reg && info.cls == CLS_RMW;
			reg_wdata_o <= alu_result_i;
		end
	end

	// Final answer; relative target only for branch classes
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			result_o <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= (state == ST_DONE);
			if (state == ST_DONE) begin
				result_o.ea <= ea;
				result_o.ea_valid <= ea_valid;
				result_o.imm <= byte1;
				result_o.imm_valid <= (info.mode == MODE_IMM);
				result_o.length <= length;
				if ((info.cls == CLS_BRANCH || info.cls == CLS_BIT_BRANCH) && branch_cond_i)
					result_o.next_pc <= target;
				else
					result_o.next_pc <= pc_next;
			end
		end
	end

	assign busy_o = (state != ST_IDLE);
endmodule // cpu_operand_address_generator
`default_nettype wire

// ### include/opaddr_pkg.sv
// Package for the operand address generator: modes, classes, sizes and carriers.
// Assumes a single 8-bit core with a 16-bit address space.
package opaddr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
	localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	typedef enum logic [2:0] {
		MODE_INH = 3'h0,
		MODE_IMM = 3'h1,
		MODE_DIR = 3'h2,
		MODE_EXT = 3'h3,
		MODE_IX = 3'h4,
		MODE_IX1 = 3'h5,
		MODE_IX2 = 3'h6,
		MODE_REL = 3'h7
	} addr_mode_t;

	typedef enum logic [2:0] {
		CLS_CONTROL = 3'h0,
		CLS_REG_MEM = 3'h1,
		CLS_RMW = 3'h2,
		CLS_TEST_NZ = 3'h3,
		CLS_BRANCH = 3'h4,
		CLS_BIT_BRANCH = 3'h5
	} instr_class_t;

	// Decoded instruction request from the sequencer
	typedef struct packed {
		addr_mode_t mode;
		instr_class_t cls;
		logic rmw_on_reg;
	} instr_info_t;

	// Operand address answer to the sequencer
	typedef struct packed {
		logic [ADDR_W-1:0] ea;
		logic ea_valid;
		logic [DATA_W-1:0] imm;
		logic imm_valid;
		logic [ADDR_W-1:0] next_pc;
		logic [1:0] length;
	} addr_result_t;
endpackage

// ### rtl/opaddr_calc.sv
// Combinational effective-address and length calculator.
// Assumes operand bytes are already captured by the caller.
`timescale 1ns/1ns
`default_nettype none
module opaddr_calc
	import opaddr_pkg::*;
(
	input wire addr_mode_t mode_i, // Addressing mode
	input wire logic [7:0] byte1_i, // First operand byte
	input wire logic [7:0] byte2_i, // Second operand byte
	input wire logic [7:0] index_i, // Index register
	input wire logic [ADDR_W-1:0] pc_next_i, // Address after instruction
	input wire logic bit_branch_i, // Three-byte test-and-branch form
	output logic [ADDR_W-1:0] ea_o, // Operand address
	output logic ea_valid_o, // Address is meaningful
	output logic [1:0] length_o, // Instruction length
	output logic [ADDR_W-1:0] target_o // Branch target if taken
);
	logic [7:0] rel_byte;

	always_comb begin
		ea_o = '0;
		ea_valid_o = 1'b0;
		length_o = LEN_ONE;
		case (mode_i)
			MODE_INH: length_o = LEN_ONE;
			MODE_IMM: length_o = LEN_TWO;
			MODE_DIR: begin
				ea_o = {ZERO_PAGE_HI, byte1_i};
				ea_valid_o = 1'b1;
				length_o = bit_branch_i ? LEN_THREE : LEN_TWO;
			end
			MODE_EXT: begin
				ea_o = {byte1_i, byte2_i};
				ea_valid_o = 1'b1;
				length_o = LEN_THREE;
			end
			MODE_IX: begin
				ea_o = {ZERO_PAGE_HI, index_i};
				ea_valid_o = 1'b1;
				length_o = LEN_ONE;
			end
			MODE_IX1: begin
				ea_o = {7'h00, {1'b0, byte1_i} + {1'b0, index_i}};
				ea_valid_o = 1'b1;
				length_o = LEN_TWO;
			end
			MODE_IX2: begin
				ea_o = {byte1_i, byte2_i} + {8'h00, index_i};
				ea_valid_o = 1'b1;
				length_o = LEN_THREE;
			end
			MODE_REL: length_o = LEN_TWO;
			default: length_o = LEN_ONE;
		endcase
	end

	// Test-and-branch carries its offset in the third byte
	assign rel_byte = bit_branch_i ? byte2_i : byte1_i;
	assign target_o = pc_next_i + {{8{rel_byte[7]}}, rel_byte};
endmodule // opaddr_calc
`default_nettype wire

// ### testbench/opaddr_mem_model.sv
// Memory bus model: answers each read one cycle later with address high xor low.
// Assumes one-cycle read strobes; writes are absorbed.
`timescale 1ns/1ns
`default_nettype none
module opaddr_mem_model (
	input wire logic clk_i, // Clock
	input wire logic rd_i, // Read strobe
	input wire logic [15:0] addr_i, // Address
	output var logic [7:0] rdata_o = 8'hA5 // Read byte
);
	// Toggles between reads so stale data never looks valid
	always @(posedge clk_i) begin
		if (rd_i)
			rdata_o <= addr_i[15:8] ^ addr_i[7:0];
		else
			rdata_o <= ~rdata_o;
	end
endmodule // opaddr_mem_model
`default_nettype wire

// ### testbench/opaddr_monitor.sv
// Port checker for the operand address generator.
// Assumes binding to the generator; mode and class latched on accepted starts.
`timescale 1ns/1ns
`default_nettype none
module opaddr_monitor import opaddr_pkg::*; (
	input wire logic ref_clk_i, // Clock
	input wire logic srst_i, // Reset
	input wire logic start_i, // Start
	input wire logic [15:0] pc_i, // Opcode address
	input wire instr_info_t info_i, // Request
	input wire logic [7:0] index_i, // Index
	input wire logic [7:0] alu_result_i, // ALU value
	input wire logic busy_o, // Busy
	input wire logic mem_rd_o, // Read
	input wire logic mem_wr_o, // Write
	input wire logic [15:0] mem_addr_o, // Address
	input wire logic [7:0] mem_wdata_o, // Write data
	input wire logic reg_wr_o, // Register write
	input wire addr_result_t result_o, // Result
	input wire logic done_o // Done
);
	addr_mode_t mode_q;
	instr_class_t cls_q;
	logic [15:0] rd_a;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			mode_q <= MODE_INH;
			cls_q <= CLS_CONTROL;
		end else if (start_i && !busy_o) begin
			mode_q <= info_i.mode;
			cls_q <= info_i.cls;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (mem_rd_o)
			rd_a <= mem_addr_o;
	end
	inh_no_bus_a: assert property (start_i && !busy_o && info_i.mode == MODE_INH
		|=> !mem_rd_o [*2]) else $error("Inherent start read memory");
	fetch_next_a: assert property (start_i && !busy_o && !(info_i.mode inside {MODE_INH, MODE_IX})
		|=> mem_rd_o && mem_addr_o == $past(pc_i) + 16'h0001) else $error("Bad operand fetch");
	dir_page_a: assert property (done_o && mode_q == MODE_DIR
		|-> result_o.ea[15:8] == ZERO_PAGE_HI) else $error("Direct high byte not zero");
	ix_page_a: assert property (done_o && mode_q == MODE_IX
		|-> result_o.ea == {ZERO_PAGE_HI, index_i}) else $error("Indexed address wrong");
	long_len_a: assert property (done_o && (mode_q inside {MODE_EXT, MODE_IX2} || cls_q == CLS_BIT_BRANCH)
		|-> result_o.length == LEN_THREE) else $error("Three-byte length wrong");
	rel_nodata_a: assert property (done_o && cls_q == CLS_BRANCH
		|-> !result_o.ea_valid) else $error("Branch gave data address");
	rmw_same_a: assert property (mem_wr_o
		|-> mem_addr_o == rd_a && mem_wdata_o == alu_result_i) else $error("Write-back wrong");
	tst_nowr_a: assert property (cls_q == CLS_TEST_NZ
		|-> !mem_wr_o && !reg_wr_o) else $error("Test wrote back");
	cover property (done_o && mode_q == MODE_IX2);
	cover property (mem_wr_o);
	cover property (reg_wr_o);
endmodule // opaddr_monitor
bind cpu_operand_address_generator opaddr_monitor opaddr_monitor_inst (.*);
`default_nettype wire

// ### testbench/cpu_operand_address_generator_tb.sv
// Testbench: every mode and class at boundary and random opcode addresses.
// Assumes the memory model byte at address a is a[15:8] xor a[7:0].
`timescale 1ns/1ns
`default_nettype none
module cpu_operand_address_generator_tb import opaddr_pkg::*;;
	logic ref_clk_i = 1'b0, srst_i = 1'b1, start_i = 1'b0, cond = 1'b0;
	logic rd, wr, busy, opv, regw, done;
	logic [15:0] pc = 16'h0000, maddr;
	logic [7:0] x = 8'h00, rv = 8'h00, alu = 8'h00, rdata, opnd, rwd, wd;
	instr_info_t info = '0;
	addr_result_t res, e, w;
	addr_result_t q[$];
	int errors = 0, n_tests = 0, seed = 32'hc86b;
	int n_wr = 0, n_regw = 0;
	// Last entry is the register form of the test instruction: read only
	addr_mode_t md[13] = '{MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX, MODE_IX1,
		MODE_IX2, MODE_DIR, MODE_IX1, MODE_INH, MODE_REL, MODE_DIR, MODE_INH};
	instr_class_t cl[13] = '{CLS_CONTROL, CLS_REG_MEM, CLS_REG_MEM, CLS_REG_MEM, CLS_REG_MEM,
		CLS_REG_MEM, CLS_REG_MEM, CLS_RMW, CLS_TEST_NZ, CLS_RMW, CLS_BRANCH, CLS_BIT_BRANCH,
		CLS_TEST_NZ};
	always #20 ref_clk_i = ~ref_clk_i;
	cpu_operand_address_generator cpu_operand_address_generator_inst (.ref_clk_i(ref_clk_i),
		.srst_i(srst_i), .start_i(start_i), .pc_i(pc), .info_i(info), .index_i(x),
		.reg_val_i(rv), .mem_rdata_i(rdata), .alu_result_i(alu), .branch_cond_i(cond),
		.busy_o(busy), .mem_rd_o(rd), .mem_wr_o(wr), .mem_addr_o(maddr), .mem_wdata_o(wd),
		.operand_o(opnd), .operand_valid_o(opv), .reg_wr_o(regw), .reg_wdata_o(rwd),
		.result_o(res), .done_o(done));
	opaddr_mem_model mem_partner_inst (.clk_i(ref_clk_i), .rd_i(rd), .addr_i(maddr),
		.rdata_o(rdata));
	function automatic logic [7:0] mb(input logic [15:0] a);
		return a[15:8] ^ a[7:0];
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("Compares %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic run(input int k);
		logic [7:0] b1, b2, off;
		int n;
		b1 = mb(pc + 16'h0001);
		b2 = mb(pc + 16'h0002);
		e = '0;
		e.length = (md[k] inside {MODE_INH, MODE_IX}) ? LEN_ONE :
			(md[k] inside {MODE_EXT, MODE_IX2} || k == 11) ? LEN_THREE : LEN_TWO;
		e.ea_valid = !(md[k] inside {MODE_INH, MODE_IMM, MODE_REL});
		e.imm_valid = (md[k] == MODE_IMM);
		e.imm = e.imm_valid ? b1 : 8'h00;
		case (md[k])
			MODE_DIR: e.ea = {ZERO_PAGE_HI, b1};
			MODE_EXT: e.ea = {b1, b2};
			MODE_IX: e.ea = {ZERO_PAGE_HI, x};
			MODE_IX1: e.ea = {8'h00, x} + {8'h00, b1};
			MODE_IX2: e.ea = {b1, b2} + {8'h00, x};
			default: e.ea = 16'h0000;
		endcase
		off = (k == 11) ? b2 : b1;
		e.next_pc = pc + {14'h0000, e.length};
		if (cl[k] inside {CLS_BRANCH, CLS_BIT_BRANCH} && cond)
			e.next_pc = e.next_pc + {{8{off[7]}}, off};
		q.push_back(e);
		info <= '{md[k], cl[k], k == 9 || k == 12};
		start_i <= 1'b1;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		for (n = 0; n < 40 && done !== 1'b1; n++)
			@(posedge ref_clk_i);
		if (n == 40) begin
			errors++;
			finish_test();
		end
	endtask
	always @(negedge ref_clk_i) begin
		if (opv === 1'b1 && q.size() > 0)
			chk(16'(opnd), q[0].ea_valid ? 16'(mb(q[0].ea)) :
				q[0].imm_valid ? 16'(q[0].imm) : 16'(rv));
		if (regw === 1'b1) begin
			n_regw++;
			chk(16'(rwd), 16'(alu));
		end
		if (wr === 1'b1 && q.size() > 0) begin
			n_wr++;
			chk(maddr, q[0].ea);
			chk(16'(wd), 16'(alu));
		end
		if (done === 1'b1) begin
			// An unexpected result meets a zero note and mismatches on length
			w = '0;
			if (q.size() > 0)
				w = q.pop_front();
			chk(16'(res.length), 16'(w.length));
			chk(16'(res.ea_valid), 16'(w.ea_valid));
			if (w.ea_valid)
				chk(res.ea, w.ea);
			chk(16'(res.imm_valid), 16'(w.imm_valid));
			if (w.imm_valid)
				chk(16'(res.imm), 16'(w.imm));
			chk(res.next_pc, w.next_pc);
		end
	end
	// First two groups hit the zero-page sum limit and both address wraps
	initial begin
		repeat (6) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		for (int r = 0; r < 10; r++) begin
			pc <= (r == 0) ? 16'h00FE : (r == 1) ? 16'hFFFD : 16'($random(seed));
			x <= (r < 2) ? 8'hFF : 8'($random(seed));
			alu <= 8'($random(seed));
			rv <= 8'($random(seed));
			cond <= (r < 2) || r[0] ^ $random(seed) & 1;
			@(posedge ref_clk_i);
			for (int k = 0; k < 13; k++)
				run(k);
			$display("Test group %0d done", r);
		end
		repeat (4) @(posedge ref_clk_i);
		// One memory and one register write-back per group, none from the tests
		chk(16'(n_wr), 16'h000A);
		chk(16'(n_regw), 16'h000A);
		finish_test();
	end
endmodule // cpu_operand_address_generator_tb
`default_nettype wire
